// ---- core/eep_mem.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose : Byte array with a write port and a registered read port
// Assumes : Write and read ports may sit on different clocks
// Notes   : Reads during a write of the same cell are not used by the slave
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module eep_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          wrClk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic          rdClk,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);

  logic [DW-1:0] cells [2**AW];

  // Programming side
  always_ff @(posedge wrClk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  // Bus side, read data from a register
  always_ff @(posedge rdClk) begin
    rdData <= cells[rdAddr];
  end

endmodule : eep_mem

// ---- core/eep_pkg.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose : Shared constants and types for the serial EEPROM slave access
// Assumes : 256-byte array, 16-byte pages, system clock of 10 MHz
// Notes   : Timing counts derive from times in their own units
//////////////////////////////////////////////////////////////////////////////
package eep_pkg;

  // Array geometry
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 8;
  localparam int PAGE_W     = 4;
  localparam int PAGE_BYTES = 16;

  // Device-type code in the upper nibble of the address byte
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'ha;

  // Bit counter marks inside a byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;

  // Direction bit values of the address byte
  localparam logic DIR_READ  = 1'h1;
  localparam logic DIR_WRITE = 1'h0;

  // Internal programming time and the derived cycle count (longest time, rounded down)
  localparam int WRITE_TIME_US = 5000;
  localparam int SYS_CLK_KHZ   = 10000;
  localparam int WRITE_CYCLES_DEF = (WRITE_TIME_US * SYS_CLK_KHZ) / 1000;

  // Bus-slave states
  typedef enum logic [2:0] {
    EEP_IDLE    = 3'b000,
    EEP_DEVADR  = 3'b001,
    EEP_WORDADR = 3'b010,
    EEP_WRDATA  = 3'b011,
    EEP_ACK     = 3'b100,
    EEP_TXDATA  = 3'b101,
    EEP_TXACK   = 3'b110
  } eep_link_state_t;

  // Programming engine states
  typedef enum logic [1:0] {
    EEP_PIDLE = 2'b00,
    EEP_PLOAD = 2'b01,
    EEP_PWAIT = 2'b10
  } eep_prog_state_t;

  // Line events seen on the synchronised bus
  typedef struct packed {
    logic start;
    logic stop;
    logic sclRise;
    logic sclFall;
  } eep_line_ev_t;

endpackage : eep_pkg

// ---- core/eep_slave.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose : Serial-bus slave access to a 256-byte EEPROM with page programming
// Assumes : linkClk samples SCL/SDA well above the bus rate; master drives SCL
// Notes   : Bus logic on linkClk, programming engine on clk_sys
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module eep_slave
  import eep_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE     = DEV_TYPE_DEFAULT,
  parameter int         WRITE_CYCLES = WRITE_CYCLES_DEF
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic linkClk,
  input  wire logic scl,
  input  wire logic sdaIn,
  output logic      sdaOut,
  output logic      sdaOe,
  input  wire logic supResetActive,
  output logic      progBusy
);

  //////////////////////////////////////////////////////////////////////////
  // Bus side: synchronised lines and events
  logic [2:0]          pinSync;
  logic                sclS;
  logic                sdaS;
  logic                rstS;
  logic                sclP_reg;
  logic                sdaP_reg;
  eep_line_ev_t        ev;
  eep_link_state_t     state_reg;
  eep_link_state_t     afterAck_reg;
  logic [3:0]          bitCnt_reg;
  logic [7:0]          shift_reg;
  logic [7:0]          txShift_reg;
  logic                masterAck_reg;
  logic [ADDR_W-1:0]   addrCnt_reg;
  logic [7:0]          pageBuf_reg [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageMask_reg;
  logic                gotData_reg;
  logic [PAGE_W-1:0]   progPage_reg;
  logic                reqTgl_reg;
  logic                doneS;
  logic                busy;
  logic                inRx;
  logic                rxDone;
  logic                addrMatch;
  logic                wordDone;
  logic                dataDone;
  logic                txLoad;
  logic                progStart;
  logic [DATA_W-1:0]   memRdData;

  // Lines enter inverted so the synchroniser's reset level reads as an idle bus
  eep_sync #(.W(3)) u_pinSync (.clk(linkClk), .reset_n(reset_n),
                               .d({!scl, !sdaIn, supResetActive}), .q(pinSync));

  assign sclS = !pinSync[2];
  assign sdaS = !pinSync[1];
  assign rstS = pinSync[0];

  // Previous line levels for edge detection
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      sclP_reg <= 1'h1;
      sdaP_reg <= 1'h1;
    end else begin
      sclP_reg <= sclS;
      sdaP_reg <= sdaS;
    end
  end

  // Conditions on the line
  assign ev.start   = sclS && sclP_reg && sdaP_reg && !sdaS;
  assign ev.stop    = sclS && sclP_reg && !sdaP_reg && sdaS;
  assign ev.sclRise = sclS && !sclP_reg;
  assign ev.sclFall = !sclS && sclP_reg;

  // Busy while a programming request is not yet answered
  assign busy = reqTgl_reg ^ doneS;

  // Byte-level decisions
  assign inRx      = (state_reg == EEP_DEVADR) || (state_reg == EEP_WORDADR)
                     || (state_reg == EEP_WRDATA);
  assign rxDone    = inRx && ev.sclFall && (bitCnt_reg == BITS_PER_BYTE);
  assign addrMatch = rxDone && (state_reg == EEP_DEVADR)
                     && (shift_reg[7:4] == DEV_TYPE) && !busy;
  assign wordDone  = rxDone && (state_reg == EEP_WORDADR);
  assign dataDone  = rxDone && (state_reg == EEP_WRDATA);
  assign txLoad    = ev.sclFall && !rstS && !ev.start && !ev.stop
                     && (((state_reg == EEP_ACK) && (afterAck_reg == EEP_TXDATA))
                     || ((state_reg == EEP_TXACK) && masterAck_reg));
  assign progStart = ev.stop && gotData_reg && !rstS && !busy;

  // Open-drain: only ever pulls low
  assign sdaOut = 1'h0;

  //////////////////////////////////////////////////////////////////////////
  // Bus state machine; START or STOP anywhere wins over byte progress
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= EEP_IDLE;
      afterAck_reg  <= EEP_IDLE;
      bitCnt_reg    <= 4'h0;
      shift_reg     <= 8'h00;
      txShift_reg   <= 8'h00;
      masterAck_reg <= 1'h0;
      sdaOe         <= 1'h0;
    end else if (rstS) begin
      state_reg <= EEP_IDLE;
      sdaOe     <= 1'h0;
    end else if (ev.start) begin
      state_reg  <= EEP_DEVADR;
      bitCnt_reg <= 4'h0;
      sdaOe      <= 1'h0;
    end else if (ev.stop) begin
      state_reg <= EEP_IDLE;
      sdaOe     <= 1'h0;
    end else begin
      case (state_reg)
        EEP_DEVADR, EEP_WORDADR, EEP_WRDATA: begin
          if (ev.sclRise && (bitCnt_reg != BITS_PER_BYTE)) begin
            shift_reg  <= {shift_reg[6:0], sdaS};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (rxDone) begin
            if ((state_reg != EEP_DEVADR) || addrMatch) begin
              state_reg <= EEP_ACK;
              sdaOe     <= 1'h1;
              if (state_reg != EEP_DEVADR) begin
                afterAck_reg <= EEP_WRDATA;
              end else if (shift_reg[0] == DIR_READ) begin
                afterAck_reg <= EEP_TXDATA;
              end else begin
                afterAck_reg <= EEP_WORDADR;
              end
            end else begin
              state_reg <= EEP_IDLE;
            end
          end
        end
        EEP_ACK: begin
          if (ev.sclFall) begin
            bitCnt_reg <= 4'h0;
            state_reg  <= afterAck_reg;
            if (afterAck_reg == EEP_TXDATA) begin
              txShift_reg <= memRdData;
              sdaOe       <= !memRdData[7];
            end else begin
              sdaOe <= 1'h0;
            end
          end
        end
        EEP_TXDATA: begin
          if (ev.sclFall) begin
            if (bitCnt_reg == LAST_TX_BIT) begin
              sdaOe     <= 1'h0;
              state_reg <= EEP_TXACK;
            end else begin
              txShift_reg <= {txShift_reg[6:0], 1'h0};
              sdaOe       <= !txShift_reg[6];
              bitCnt_reg  <= bitCnt_reg + 4'h1;
            end
          end
        end
        EEP_TXACK: begin
          if (ev.sclRise) begin
            masterAck_reg <= !sdaS;
          end
          if (ev.sclFall) begin
            bitCnt_reg <= 4'h0;
            if (masterAck_reg) begin
              state_reg   <= EEP_TXDATA;
              txShift_reg <= memRdData;
              sdaOe       <= !memRdData[7];
            end else begin
              state_reg <= EEP_IDLE;
            end
          end
        end
        default: begin
          state_reg <= EEP_IDLE;
          sdaOe     <= 1'h0;
        end
      endcase
    end
  end

  // Address counter: word address load, in-page step, full step on reads
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      addrCnt_reg <= 8'h00;
    end else if (wordDone && !rstS) begin
      addrCnt_reg <= shift_reg;
    end else if (dataDone && !rstS) begin
      addrCnt_reg <= {addrCnt_reg[7:4], addrCnt_reg[3:0] + 4'h1};
    end else if (txLoad) begin
      addrCnt_reg <= addrCnt_reg + 8'h01;
    end
  end

  // Page buffer; stays frozen while the engine copies it, since busy blocks writes
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      pageMask_reg <= '0;
      gotData_reg  <= 1'h0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pageBuf_reg[i] <= 8'h00;
      end
    end else if (rstS || ev.start || ev.stop) begin
      gotData_reg <= 1'h0;
    end else if (addrMatch && (shift_reg[0] == DIR_WRITE)) begin
      pageMask_reg <= '0;
    end else if (dataDone) begin
      pageBuf_reg[addrCnt_reg[3:0]]  <= shift_reg;
      pageMask_reg[addrCnt_reg[3:0]] <= 1'h1;
      gotData_reg                    <= 1'h1;
    end
  end

  // Programming request toggle with the page it belongs to
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      reqTgl_reg   <= 1'h0;
      progPage_reg <= 4'h0;
    end else if (progStart) begin
      reqTgl_reg   <= !reqTgl_reg;
      progPage_reg <= addrCnt_reg[7:4];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Programming engine on clk_sys; a started cycle always runs to the end
  eep_prog_state_t pState_reg;
  logic [PAGE_W-1:0] pIdx_reg;
  logic [15:0]       pTimer_reg;
  logic              doneTgl_reg;
  logic              reqS;
  logic              memWe;

  eep_sync #(.W(1)) u_reqSync (.clk(clk_sys), .reset_n(reset_n), .d(reqTgl_reg), .q(reqS));
  eep_sync #(.W(1)) u_doneSync (.clk(linkClk), .reset_n(reset_n), .d(doneTgl_reg), .q(doneS));

  // Page buffer and page are stable across the handshake, so read directly
  assign memWe = (pState_reg == EEP_PLOAD) && pageMask_reg[pIdx_reg];

  // Copy the masked page, then hold busy for the whole programming time
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pState_reg  <= EEP_PIDLE;
      pIdx_reg    <= 4'h0;
      pTimer_reg  <= 16'h0000;
      doneTgl_reg <= 1'h0;
      progBusy    <= 1'h0;
    end else begin
      case (pState_reg)
        EEP_PIDLE: begin
          if (reqS != doneTgl_reg) begin
            pState_reg <= EEP_PLOAD;
            pIdx_reg   <= 4'h0;
            progBusy   <= 1'h1;
          end
        end
        EEP_PLOAD: begin
          pIdx_reg <= pIdx_reg + 4'h1;
          if (pIdx_reg == 4'hf) begin
            pState_reg <= EEP_PWAIT;
            pTimer_reg <= 16'(WRITE_CYCLES - 1);
          end
        end
        EEP_PWAIT: begin
          if (pTimer_reg == 16'h0000) begin
            pState_reg  <= EEP_PIDLE;
            doneTgl_reg <= !doneTgl_reg;
            progBusy    <= 1'h0;
          end else begin
            pTimer_reg <= pTimer_reg - 16'h0001;
          end
        end
        default: begin
          pState_reg <= EEP_PIDLE;
        end
      endcase
    end
  end

  eep_mem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .wrClk  (clk_sys),
    .wrEn   (memWe),
    .wrAddr ({progPage_reg, pIdx_reg}),
    .wrData (pageBuf_reg[pIdx_reg]),
    .rdClk  (linkClk),
    .rdAddr (addrCnt_reg),
    .rdData (memRdData)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks on the bus side
  sequence ackHeld_s;
    sdaOe && (state_reg == EEP_ACK);
  endsequence
  sequence goodAddr_s;
    rxDone && (state_reg == EEP_DEVADR) && (shift_reg[7:4] == DEV_TYPE) && !busy
      && !rstS && !ev.start && !ev.stop;
  endsequence
  addr_ack_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    goodAddr_s |=> ackHeld_s) else $error("matching address not acknowledged");
  addr_mismatch_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    (rxDone && (state_reg == EEP_DEVADR) && (shift_reg[7:4] != DEV_TYPE) && !rstS
      && !ev.start && !ev.stop) |=> (state_reg == EEP_IDLE) && !sdaOe)
    else $error("foreign address acknowledged");
  busy_silent_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    (busy && (state_reg == EEP_DEVADR)) |=> !sdaOe) else $error("acknowledged while busy");
  ack_release_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    (ackHeld_s ##1 (ev.sclFall && !rstS && !ev.start && !ev.stop
      && (afterAck_reg != EEP_TXDATA))) |=> !sdaOe)
    else $error("acknowledge not released after ninth clock");
  start_restart_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    (ev.start && !rstS) |=> (state_reg == EEP_DEVADR) && !sdaOe && (bitCnt_reg == 4'h0))
    else $error("start did not restart address reception");
  supreset_abort_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    rstS |=> (state_reg == EEP_IDLE) && !sdaOe && ($stable(reqTgl_reg)))
    else $error("transfer continued under supervisor reset");
  stop_program_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    progStart |=> busy ##1 busy) else $error("stop after data did not start programming");
  dummy_write_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    (ev.stop && !gotData_reg) |=> $stable(reqTgl_reg))
    else $error("address-only write started programming");
  page_step_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    (dataDone && !rstS) |=> (addrCnt_reg[7:4] == $past(addrCnt_reg[7:4]))
      && (addrCnt_reg[3:0] == $past(addrCnt_reg[3:0]) + 4'h1))
    else $error("page write address step wrong");
  read_step_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    txLoad |=> (addrCnt_reg == $past(addrCnt_reg) + 8'h01) && (state_reg == EEP_TXDATA))
    else $error("read did not advance the address counter");
  nack_end_a: assert property (@(posedge linkClk) disable iff (!reset_n)
    ((state_reg == EEP_TXACK) && ev.sclFall && !masterAck_reg && !rstS
      && !ev.start && !ev.stop) |=> (state_reg == EEP_IDLE) && !sdaOe)
    else $error("transmission continued after missing acknowledge");
  // Check on the programming side
  prog_done_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $changed(doneTgl_reg) |-> $past(pState_reg == EEP_PWAIT) && $past(pTimer_reg == 16'h0000))
    else $error("programming ended before its time");

endmodule : eep_slave

// ---- core/eep_sync.sv ----
//////////////////////////////////////////////////////////////////////////////
// Purpose : Two-flop synchroniser for levels entering a clock domain
// Assumes : Each bit is an independent level or toggle
// Notes   : The first stage is read by the second stage only
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module eep_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // Two stages, reset to zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule : eep_sync

// ---- verif/eep_master.sv ----
////////////////////////////////////////////////////////////////////////////
// Purpose : Bus master model driving clock and data toward the slave
// Assumes : Each bit-clock phase lasts 8 link cycles; data line has a pull-up
// Notes   : The bench calls its tasks; pins change on falling linkClk only
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module eep_master (
  input  wire logic linkClk,
  input  wire logic sdaOe,
  input  wire logic sdaOut,
  output logic      scl,
  output logic      sda
);
  logic sdaLow;
  logic dummy;

  // Wired-AND with pull-up: a released line reads high, never a stale value
  assign sda = (sdaLow || (sdaOe && !sdaOut)) ? 1'h0 : 1'h1;

  // Bus idle from time zero
  initial begin
    scl    = 1'h1;
    sdaLow = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic waitN(input int n);
    repeat (n) @(negedge linkClk);
  endtask : waitN

  // One clock; data moves late in the low phase so the slave's delayed
  // release of the line never collides with it
  task automatic bitCycle(input logic b, output logic seen);
    waitN(5);
    sdaLow = !b;
    waitN(3);
    scl = 1'h1;
    waitN(4);
    seen = sda;
    waitN(4);
    scl = 1'h0;
  endtask : bitCycle

  // Data falls while clock high
  task automatic start();
    waitN(5);
    sdaLow = 1'h0;
    waitN(3);
    scl = 1'h1;
    waitN(8);
    sdaLow = 1'h1;
    waitN(8);
    scl = 1'h0;
  endtask : start

  // Data rises while clock high; leaves the bus idle
  task automatic stop();
    waitN(5);
    sdaLow = 1'h1;
    waitN(3);
    scl = 1'h1;
    waitN(8);
    sdaLow = 1'h0;
    waitN(8);
  endtask : stop

  // Eight bits MSB first, then release and sample the ninth clock
  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bitCycle(b[i], dummy);
    end
    bitCycle(1'h1, seen);
    ack = !seen;
  endtask : sendByte

  // Receive eight bits, then pull low in the ninth clock to ask for more
  task automatic recvByte(output logic [7:0] b, input logic ackIt);
    for (int i = 7; i >= 0; i--) begin
      bitCycle(1'h1, b[i]);
    end
    bitCycle(!ackIt, dummy);
  endtask : recvByte
endmodule : eep_master

// ---- verif/test_i2c_eeprom_slave_access.sv ----
////////////////////////////////////////////////////////////////////////////
// Purpose : Self-checking bench for the serial EEPROM slave
// Assumes : Shortened programming time; master model on a 32 ns link clock
// Notes   : Each scenario judges its own results before returning
////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module test_i2c_eeprom_slave_access
  import eep_pkg::*;
;
  localparam int         PROG_CYCLES = 200;
  localparam int         RUN_LIMIT   = 30000;
  localparam logic [7:0] ADR_WR      = {DEV_TYPE_DEFAULT, 3'h0, DIR_WRITE};
  localparam logic [7:0] ADR_RD      = {DEV_TYPE_DEFAULT, 3'h0, DIR_READ};

  logic       clk_sys = 1'h0;
  logic       linkClk = 1'h0;
  logic       reset_n;
  logic       supResetActive;
  logic       scl;
  logic       sda;
  logic       sdaOut;
  logic       sdaOe;
  logic       progBusy;
  logic       ack;
  logic [7:0] rdBuf [0:15];
  int         num_errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  // Link clock starts off phase so the two domains never line up
  always #50 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #16 linkClk = ~linkClk;
  end

  eep_slave #(.DEV_TYPE(DEV_TYPE_DEFAULT), .WRITE_CYCLES(PROG_CYCLES)) uut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .linkClk(linkClk),
    .scl(scl),
    .sdaIn(sda),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .supResetActive(supResetActive),
    .progBusy(progBusy)
  );

  eep_master m (.linkClk(linkClk), .sdaOe(sdaOe), .sdaOut(sdaOut), .scl(scl), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Writes n bytes counting up from first, then expects programming to start
  task automatic writeSeq(input logic [7:0] addr, input int n, input logic [7:0] first);
    m.start();
    m.sendByte(ADR_WR, ack);
    check("addr ack", {7'h0, ack}, 8'h01);
    m.sendByte(addr, ack);
    check("word ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.sendByte(first + 8'(i), ack);
      check("data ack", {7'h0, ack}, 8'h01);
    end
    m.stop();
    repeat (10) @(negedge clk_sys);
    check("busy set", {7'h0, progBusy}, 8'h01);
  endtask : writeSeq

  // Bounded wait: a stuck busy flag must not hang the run
  task automatic waitIdle();
    int n;
    n = 0;
    while (progBusy !== 1'h0 && n < 1000) begin
      @(negedge clk_sys);
      n++;
    end
    check("busy clear", {7'h0, progBusy}, 8'h00);
  endtask : waitIdle

  // Optional dummy write of the address, then n bytes, nack on the last
  task automatic readBytes(input logic useAddr, input logic [7:0] addr, input int n);
    if (useAddr) begin
      m.start();
      m.sendByte(ADR_WR, ack);
      m.sendByte(addr, ack);
      check("dummy ack", {7'h0, ack}, 8'h01);
    end
    m.start();
    m.sendByte(ADR_RD, ack);
    check("read ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m.recvByte(rdBuf[i], i < n - 1);
    end
    m.waitN(8);
    check("released", {7'h0, sdaOe}, 8'h00);
    m.stop();
  endtask : readBytes

  ////////////////////////////////////////////////////////////////////////////
  task automatic testByteWrite();
    writeSeq(8'h3F, 1, 8'h5A);
    m.start();
    m.sendByte(ADR_WR, ack);
    check("busy poll", {7'h0, ack}, 8'h00);
    m.stop();
    waitIdle();
    m.start();
    m.sendByte(ADR_WR, ack);
    check("done poll", {7'h0, ack}, 8'h01);
    m.stop();
    repeat (10) @(negedge clk_sys);
    check("no prog", {7'h0, progBusy}, 8'h00);
    readBytes(1'h1, 8'h3F, 1);
    check("random", rdBuf[0], 8'h5A);
    check("dummy no prog", {7'h0, progBusy}, 8'h00);
    $display("test byte write done");
  endtask : testByteWrite

  // One bit off in the type nibble: nothing of the transfer is answered
  task automatic testWrongType();
    m.start();
    m.sendByte(ADR_WR ^ 8'h10, ack);
    check("type nack", {7'h0, ack}, 8'h00);
    m.sendByte(8'h00, ack);
    check("ignored", {7'h0, ack}, 8'h00);
    m.stop();
    $display("test wrong type done");
  endtask : testWrongType

  // 18 bytes from offset 2: the last two land on offsets 2 and 3 again
  task automatic testPageWrap();
    logic [7:0] exp;
    writeSeq(8'h12, 18, 8'h40);
    waitIdle();
    readBytes(1'h0, 8'h00, 1);
    check("current", rdBuf[0], 8'h42);
    readBytes(1'h1, 8'h10, 16);
    for (int k = 0; k < 16; k++) begin
      exp = 8'h40 + 8'((k + 14) % 16) + ((k == 2 || k == 3) ? 8'h10 : 8'h00);
      check("page", rdBuf[k], exp);
    end
    $display("test page wrap done");
  endtask : testPageWrap

  task automatic testWrapRead();
    writeSeq(8'hFF, 1, 8'hC3);
    waitIdle();
    writeSeq(8'h00, 1, 8'h3C);
    waitIdle();
    readBytes(1'h1, 8'hFF, 2);
    check("wrap 0", rdBuf[0], 8'hC3);
    check("wrap 1", rdBuf[1], 8'h3C);
    $display("test wrap read done");
  endtask : testWrapRead

  // Running cycle completes under supervisor reset; new transfers refused
  task automatic testSupReset();
    writeSeq(8'h80, 1, 8'h77);
    supResetActive = 1'h1;
    waitIdle();
    m.start();
    m.sendByte(ADR_WR, ack);
    check("sup nack", {7'h0, ack}, 8'h00);
    m.sendByte(8'h80, ack);
    m.sendByte(8'h11, ack);
    m.stop();
    repeat (10) @(negedge clk_sys);
    check("sup no prog", {7'h0, progBusy}, 8'h00);
    supResetActive = 1'h0;
    repeat (4) @(negedge clk_sys);
    readBytes(1'h1, 8'h80, 1);
    check("sup kept", rdBuf[0], 8'h77);
    $display("test supervisor reset done");
  endtask : testSupReset

  // START after three bits must restart address decoding
  task automatic testMidStart();
    m.start();
    m.bitCycle(1'h1, ack);
    m.bitCycle(1'h0, ack);
    m.bitCycle(1'h1, ack);
    readBytes(1'h1, 8'h3F, 1);
    check("mid start", rdBuf[0], 8'h5A);
    $display("test mid-byte start done");
  endtask : testMidStart

  ////////////////////////////////////////////////////////////////////////////
  // Cycle ceiling well above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == RUN_LIMIT) begin
      num_errors++;
      summarize();
    end
  end

  // Reset, then the scenarios in turn
  initial begin
    reset_n        = 1'h0;
    supResetActive = 1'h0;
    repeat (16) @(negedge clk_sys);
    reset_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    testByteWrite();
    testWrongType();
    testPageWrap();
    testWrapRead();
    testSupReset();
    testMidStart();
    summarize();
  end
endmodule : test_i2c_eeprom_slave_access
